// file: hdl/power_mode_pkg.sv
package power_mode_pkg;

  // Register offsets on the register port
  localparam logic [7:0] POWER_CONTROL_ONE_OFFSET  = 8'h0E;
  localparam logic [7:0] SLEEP_DELAY_COUNT_OFFSET  = 8'h0F;

  // Field positions in power_control_one
  localparam int         PLL_DOWN_BIT              = 5;
  localparam int         MODE_HI_BIT               = 4;
  localparam int         MODE_LO_BIT               = 3;
  localparam int         SPARE_HI_BIT              = 2;
  localparam int         SPARE_LO_BIT              = 1;

  // Power state field encodings
  localparam logic [1:0] MODE_FULL_POWER           = 2'h0;
  localparam logic [1:0] MODE_ENERGY_DETECT        = 2'h1;
  localparam logic [1:0] MODE_SOFT_OFF             = 2'h2;
  localparam logic [1:0] MODE_SAVING               = 2'h3;

  // Reset values
  localparam logic [1:0] MODE_RESET                = 2'h0;
  localparam logic       PLL_DOWN_RESET            = 1'h0;
  localparam logic [1:0] SPARE_RESET               = 2'h0;
  localparam logic [7:0] SLEEP_DELAY_RESET         = 8'h50;
  localparam logic [7:0] UNMAPPED_READ_VALUE       = 8'h00;

  // Strap level that selects energy detection at reset
  localparam logic       STRAP_ENERGY_LEVEL        = 1'h0;

  // Timing
  localparam int         CLOCK_PERIOD_NS           = 10;
  localparam int         SLEEP_UNIT_MS             = 20;
  localparam int         SLEEP_UNIT_CYCLES         = SLEEP_UNIT_MS * 1000000 / CLOCK_PERIOD_NS;
  localparam int         SOFT_OFF_SETTLE_CYCLES    = 8;

  localparam int         PORT_COUNT                = 5;

endpackage : power_mode_pkg

// file: hdl/quiet_timer.sv
`timescale 1ns/10ps
`default_nettype none

module quiet_timer
#(
  parameter int unsigned UNIT_CYCLES = power_mode_pkg::SLEEP_UNIT_CYCLES
)
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       run,
  input  wire logic       energy_seen,
  input  wire logic [7:0] delay_units,
  output logic            quiet_done
);
  import power_mode_pkg::*;

  typedef struct packed
  {
    logic [31:0] cycle_count;
    logic [7:0]  units;
    logic        done;
  } timer_s;

  timer_s state;
  timer_s next_state;

  always_comb
  begin
    next_state = state;
    if (!run || energy_seen)
    begin
      // Any energy restarts the quiet interval from zero
      next_state.cycle_count = 32'h0;
      next_state.units       = 8'h00;
      next_state.done        = 1'b0;
    end
    else if (!state.done)
    begin
      if (state.units >= delay_units)
      begin
        next_state.done = 1'b1;
      end
      else if (state.cycle_count == UNIT_CYCLES - 32'h1)
      begin
        next_state.cycle_count = 32'h0;
        next_state.units       = state.units + 8'h01;
      end
      else
      begin
        next_state.cycle_count = state.cycle_count + 32'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign quiet_done = state.done;

endmodule : quiet_timer

`default_nettype wire

// file: hdl/switch_power_mode_control.sv
// Overview of operation
// - The two-bit power state field selects full power for 00, energy detection for 01, soft off for 10 and power saving for 11.
// - The power state field sits in bits 4 to 3 of power_control_one and is readable and writable.
// - After reset the power state field is loaded from the strap pin: low selects energy detection, high selects full power.
// - Bit 5 lets the PLL power down during energy-detect power-down, otherwise the PLL stays on; it resets to 0.
// - The sleep delay count resets to 0x50, eighty units or 1.6 s.
`timescale 1ns/10ps
`default_nettype none

module switch_power_mode_control
#(
  parameter int unsigned SLEEP_UNIT_CYCLES = power_mode_pkg::SLEEP_UNIT_CYCLES
)
(
  input  wire logic                              clock,
  input  wire logic                              resetn,
  input  wire logic [7:0]                        reg_addr,
  input  wire logic                              reg_write,
  input  wire logic [7:0]                        reg_wdata,
  input  wire logic                              reg_read,
  output logic      [7:0]                        reg_rdata,
  output logic                                   reg_rdata_valid,
  input  wire logic                              power_state_strap_pin,
  input  wire logic [power_mode_pkg::PORT_COUNT-1:0] port_energy,
  output logic                                   full_power_state,
  output logic                                   saving_state,
  output logic                                   energy_detect_state,
  output logic                                   soft_off_state,
  output logic                                   energy_detect_power_down,
  output logic                                   pll_power_down
);
  import power_mode_pkg::*;

  typedef enum logic [2:0]
  {
    st_full,
    st_saving,
    st_energy_watch,
    st_energy_sleep,
    st_soft_pending,
    st_soft_off
  } power_state_e;

  typedef struct packed
  {
    logic         strap_done;
    logic [1:0]   mode;
    logic         pll_down_enable;
    logic [1:0]   spare;
    logic [7:0]   sleep_delay;
    logic [7:0]   rdata;
    logic         rvalid;
    power_state_e pstate;
    logic [3:0]   settle;
  } control_s;

  control_s state;
  control_s next_state;

  logic write_one;
  logic read_one;
  logic quiet_done;

  function automatic power_state_e state_for_mode(input logic [1:0] mode);
    power_state_e result;
    result = st_full;
    if (mode == MODE_ENERGY_DETECT)
    begin
      result = st_energy_watch;
    end
    else if (mode == MODE_SOFT_OFF)
    begin
      result = st_soft_pending;
    end
    else if (mode == MODE_SAVING)
    begin
      result = st_saving;
    end
    return result;
  endfunction : state_for_mode

  function automatic logic [7:0] control_one_image(input control_s s);
    logic [7:0] image;
    image                            = 8'h00;
    image[PLL_DOWN_BIT]              = s.pll_down_enable;
    image[MODE_HI_BIT:MODE_LO_BIT]   = s.mode;
    image[SPARE_HI_BIT:SPARE_LO_BIT] = s.spare;
    return image;
  endfunction : control_one_image

  assign write_one = reg_write && (reg_addr == POWER_CONTROL_ONE_OFFSET);
  assign read_one  = reg_read && (reg_addr == POWER_CONTROL_ONE_OFFSET);

  quiet_timer
  #(
    .UNIT_CYCLES (SLEEP_UNIT_CYCLES)
  )
  u_quiet_timer
  (
    .clock       (clock),
    .resetn      (resetn),
    .run         (state.pstate == st_energy_watch),
    .energy_seen (|port_energy),
    .delay_units (state.sleep_delay),
    .quiet_done  (quiet_done)
  );

  always_comb
  begin
    next_state        = state;
    next_state.rvalid = 1'b0;

    // Read data path, registered
    if (reg_read)
    begin
      next_state.rvalid = 1'b1;
      if (reg_addr == POWER_CONTROL_ONE_OFFSET)
      begin
        next_state.rdata = control_one_image(state);
      end
      else if (reg_addr == SLEEP_DELAY_COUNT_OFFSET)
      begin
        next_state.rdata = state.sleep_delay;
      end
      else
      begin
        next_state.rdata = UNMAPPED_READ_VALUE;
      end
    end

    // Power state sequencing
    case (state.pstate)
      st_energy_watch:
      begin
        if (quiet_done)
        begin
          next_state.pstate = st_energy_sleep;
        end
      end
      st_energy_sleep:
      begin
        if (|port_energy)
        begin
          next_state.pstate = st_energy_watch;
        end
      end
      st_soft_pending:
      begin
        if (read_one)
        begin
          // Read-back abandons the request; a fresh write is needed
          next_state.pstate = st_full;
        end
        else if (state.settle == 4'h0)
        begin
          next_state.pstate = st_soft_off;
        end
        else
        begin
          next_state.settle = state.settle - 4'h1;
        end
      end
      default:
      begin
        next_state.pstate = state.pstate;
      end
    endcase

    // Strap capture on the first edge after reset release
    if (!state.strap_done)
    begin
      next_state.strap_done = 1'b1;
      if (power_state_strap_pin == STRAP_ENERGY_LEVEL)
      begin
        next_state.mode   = MODE_ENERGY_DETECT;
        next_state.pstate = st_energy_watch;
      end
      else
      begin
        next_state.mode   = MODE_FULL_POWER;
        next_state.pstate = st_full;
      end
    end

    // Register writes win over the sequencing above
    if (write_one)
    begin
      next_state.pll_down_enable = reg_wdata[PLL_DOWN_BIT];
      next_state.mode            = reg_wdata[MODE_HI_BIT:MODE_LO_BIT];
      next_state.spare           = reg_wdata[SPARE_HI_BIT:SPARE_LO_BIT];
      next_state.strap_done      = 1'b1;
      if (state.pstate == st_soft_off
          && reg_wdata[MODE_HI_BIT:MODE_LO_BIT] == MODE_SOFT_OFF)
      begin
        next_state.pstate = st_soft_off;
      end
      else
      begin
        next_state.pstate = state_for_mode(reg_wdata[MODE_HI_BIT:MODE_LO_BIT]);
        next_state.settle = 4'(SOFT_OFF_SETTLE_CYCLES - 1);
      end
    end
    else if (reg_write && reg_addr == SLEEP_DELAY_COUNT_OFFSET)
    begin
      next_state.sleep_delay = reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state.strap_done      <= 1'b0;
      state.mode            <= MODE_RESET;
      state.pll_down_enable <= PLL_DOWN_RESET;
      state.spare           <= SPARE_RESET;
      state.sleep_delay     <= SLEEP_DELAY_RESET;
      state.rdata           <= 8'h00;
      state.rvalid          <= 1'b0;
      state.pstate          <= st_full;
      state.settle          <= 4'h0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign reg_rdata                = state.rdata;
  assign reg_rdata_valid          = state.rvalid;
  assign full_power_state         = (state.pstate == st_full)
                                    || (state.pstate == st_soft_pending);
  assign saving_state             = (state.pstate == st_saving);
  assign energy_detect_state      = (state.pstate == st_energy_watch)
                                    || (state.pstate == st_energy_sleep);
  assign soft_off_state           = (state.pstate == st_soft_off);
  assign energy_detect_power_down = (state.pstate == st_energy_sleep);
  assign pll_power_down           = state.pll_down_enable
                                    && (state.pstate == st_energy_sleep);

endmodule : switch_power_mode_control

`default_nettype wire

// file: testbench/power_mode_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module power_mode_asserts
(
  input wire logic                            clock,
  input wire logic                            resetn,
  input wire logic [7:0]                      reg_addr,
  input wire logic                            reg_write,
  input wire logic [7:0]                      reg_wdata,
  input wire logic                            reg_read,
  input wire logic [7:0]                      reg_rdata,
  input wire logic                            reg_rdata_valid,
  input wire logic [power_mode_pkg::PORT_COUNT-1:0] port_energy,
  input wire logic                            full_power_state,
  input wire logic                            saving_state,
  input wire logic                            energy_detect_state,
  input wire logic                            soft_off_state,
  input wire logic                            energy_detect_power_down,
  input wire logic                            pll_power_down
);
  import power_mode_pkg::*;
  logic w0e;
  logic [1:0] wm;
  assign w0e = reg_write && reg_addr == POWER_CONTROL_ONE_OFFSET;
  assign wm = reg_wdata[4:3];
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  a_read_answer: assert property (reg_read |=> reg_rdata_valid)
    else $error("read not answered");
  a_no_stray: assert property (!reg_read |=> !reg_rdata_valid)
    else $error("stray read valid");
  a_spare_zero: assert property (reg_read && reg_addr == POWER_CONTROL_ONE_OFFSET
    |=> reg_rdata[7:6] == 2'h0 && !reg_rdata[0]) else $error("fixed bits not 0");
  a_state_onehot: assert property ($onehot({full_power_state, saving_state,
    energy_detect_state, soft_off_state})) else $error("state not one-hot");
  a_mode_full: assert property (w0e && wm == MODE_FULL_POWER |=> full_power_state)
    else $error("full power not taken");
  a_mode_energy: assert property (w0e && wm == MODE_ENERGY_DETECT |=> energy_detect_state)
    else $error("energy detect not taken");
  a_mode_saving: assert property (w0e && wm == MODE_SAVING |=> saving_state)
    else $error("saving not taken");
  a_soft_wait: assert property (w0e && wm == MODE_SOFT_OFF && !soft_off_state
    |=> !soft_off_state[*8]) else $error("soft off too early");
  a_pll_gate: assert property (pll_power_down |-> energy_detect_power_down)
    else $error("pll down outside sleep");
  a_sleep_mode: assert property (energy_detect_power_down |-> energy_detect_state)
    else $error("sleep outside energy detect");
  a_energy_wake: assert property (|port_energy && energy_detect_power_down
    |=> !energy_detect_power_down) else $error("no wake on energy");
endmodule : power_mode_asserts
bind switch_power_mode_control power_mode_asserts chk (.clock(clock), .resetn(resetn),
  .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
  .port_energy(port_energy), .full_power_state(full_power_state),
  .saving_state(saving_state), .energy_detect_state(energy_detect_state),
  .soft_off_state(soft_off_state), .energy_detect_power_down(energy_detect_power_down),
  .pll_power_down(pll_power_down));
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import power_mode_pkg::*;
  localparam int U = 4;
  logic clock = 0, resetn = 0, reg_write = 0, reg_read = 0, strap = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v, st;
  logic reg_rdata_valid, full_s, save_s, ed_s, off_s, ed_pd, pll_pd;
  logic [PORT_COUNT-1:0] energy = '0;
  int bad_count = 0, checks_done = 0, cycles = 0, k, d;
  assign st = {4'h0, full_s, save_s, ed_s, off_s};
  switch_power_mode_control #(.SLEEP_UNIT_CYCLES(U)) DUT (.clock(clock), .resetn(resetn),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
    .power_state_strap_pin(strap), .port_energy(energy), .full_power_state(full_s),
    .saving_state(save_s), .energy_detect_state(ed_s), .soft_off_state(off_s),
    .energy_detect_power_down(ed_pd), .pll_power_down(pll_pd));
  initial forever #5 clock = ~clock;
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = dt;
    reg_write = 1;
    @(negedge clock);
    reg_write = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1;
    @(negedge clock);
    reg_read = 0;
    chk({7'h00, reg_rdata_valid}, 8'h01);
    chk(reg_rdata, exp);
  endtask : rd
  task automatic do_reset(input logic s);
    resetn = 0;
    strap = s;
    repeat (12) @(negedge clock);
    resetn = 1;
    repeat (2) @(negedge clock);
  endtask : do_reset
  task automatic wait_sleep();
    k = 0;
    while (ed_pd !== 1'b1 && k < 99)
    begin
      @(negedge clock);
      k++;
    end
  endtask : wait_sleep
  function automatic logic [7:0] states(input logic [1:0] m);
    return (m == MODE_ENERGY_DETECT) ? 8'h02 : (m == MODE_SAVING) ? 8'h04 : 8'h08;
  endfunction : states
  initial
  begin
    void'($urandom(57));
    do_reset(0);
    chk(st, 8'h02);
    rd(POWER_CONTROL_ONE_OFFSET, 8'h08);
    do_reset(1);
    chk(st, 8'h08);
    rd(POWER_CONTROL_ONE_OFFSET, 8'h00);
    rd(SLEEP_DELAY_COUNT_OFFSET, SLEEP_DELAY_RESET);
    rd(8'h33, UNMAPPED_READ_VALUE);
    for (int i = 0; i < 8; i++)
    begin
      v = 8'($urandom);
      v[4:3] = 2'(i);
      v[2:1] = 2'h0;
      wr(POWER_CONTROL_ONE_OFFSET, v);
      chk(st, states(v[4:3]));
      rd(POWER_CONTROL_ONE_OFFSET, v & 8'h3E);
    end
    wr(POWER_CONTROL_ONE_OFFSET, 8'h00);
    wr(POWER_CONTROL_ONE_OFFSET, 8'h10);
    rd(SLEEP_DELAY_COUNT_OFFSET, SLEEP_DELAY_RESET);
    repeat (7) @(negedge clock);
    chk(st, 8'h01);
    wr(POWER_CONTROL_ONE_OFFSET, 8'h00);
    wr(POWER_CONTROL_ONE_OFFSET, 8'h10);
    rd(POWER_CONTROL_ONE_OFFSET, 8'h10);
    repeat (9) @(negedge clock);
    chk(st, 8'h08);
    d = $urandom_range(3, 1);
    wr(SLEEP_DELAY_COUNT_OFFSET, 8'(d));
    energy = 5'($urandom_range(31, 1));
    wr(POWER_CONTROL_ONE_OFFSET, 8'h28);
    repeat (d * U + 3) @(negedge clock);
    chk({7'h00, ed_pd}, 8'h00);
    energy = '0;
    repeat (d * U - 1) @(negedge clock);
    energy = 5'($urandom_range(31, 1));
    @(negedge clock);
    energy = '0;
    wait_sleep();
    chk(8'(k >= d * U && k <= d * U + 3), 8'h01);
    chk({6'h00, ed_pd, pll_pd}, 8'h03);
    energy = 5'h10;
    @(negedge clock);
    chk({7'h00, ed_pd}, 8'h00);
    energy = '0;
    wr(POWER_CONTROL_ONE_OFFSET, 8'h08);
    wait_sleep();
    chk({6'h00, ed_pd, pll_pd}, 8'h02);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
